// [hw/cbt_tap.sv]
// module: test access port with 63-cell boundary chain of the cam device
`timescale 1ns/1ps
`default_nettype none

// overview of the test port
// the port lives almost wholly on the tester's clock; only the pad
// drivers and the mode levels live on the system clock
//
// tck domain
// - sixteen-state controller, advanced by mode select on rising tck
// - four-bit instruction shifter and the active instruction
// - 63-bit boundary shifter and its update (preload) word
// - one-bit bypass cell, which captures zero
// - two-stage synchroniser for the observed pad values
//
// falling tck stage
// - data out and its enable are registered on the falling edge
// - the tester samples on rising tck, so it sees a full half period
//   of settled data
// - the enable is high only in the two shift states; outside them the
//   data out flop is parked at zero so no stale bit leaks out
//
// ref_clk domain
// - drive and high-impedance mode levels cross through two flops each
// - the preload word crosses as a bundle, qualified by a toggle that
//   passes three flops; the word is written on the same tck edge as
//   the toggle and held for several tck cycles after, so no bit can be caught mid-way
// - the pads follow the core one ref_clk later unless a drive mode
//   is in force
//
// resets
// - the test reset is asynchronous and only touches tck state; the
//   falling-edge stage is reset with it so data out drops at once
// - the system reset is synchronous and only touches ref_clk state
// - neither reset reaches the other side, so a port reset never
//   disturbs the core's use of the pads
//
// floating inputs
// - the driven flags stand for the pad's weak pull-up; when a line is
//   released its level is ignored and read as one
// - a tester that lets mode select float therefore walks the
//   controller home in five clocks
//
// instruction handling
// - unknown codes behave as bypass: no drive, no high impedance and
//   the one-bit path selected
// - the new code and its mode levels take effect on the rising edge
//   that leaves the update-instruction state
// - the test-logic-reset state reloads the bypass code on every edge
//   it is held, so a glitch on the instruction cannot survive it
//
// limitations
// - the capture of pad values lags the pads by two tck edges; pads
//   that move faster than that are sampled at some point in between
// - clamp and high impedance keep the last preload; shifting data
//   under them goes only through the bypass cell
// - pad values seen on the system side lag the tck update by three
//   to four ref_clk cycles
//
// trade-off
// - the toggle crossing costs a few cycles of latency but needs no
//   return path, so the tck side never waits on the system clock

module cbt_tap (
  // system clock domain
  input wire logic ref_clk,
  input wire logic rst,
  // test port, clocked by the tester
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms_pin,
  input wire logic tms_driven,
  input wire logic tdi_pin,
  input wire logic tdi_driven,
  output logic tdo,
  output logic tdo_oe,
  // core and pad side of the boundary cells
  input wire cbt_pkg::cbt_pins_t pad_in,
  input wire cbt_pkg::cbt_pins_t core_out,
  output cbt_pkg::cbt_pins_t pad_out,
  output logic pad_hiz,
  output logic pad_test_mode
);
  import cbt_pkg::*;

  // test clock domain state
  typedef struct packed {
    cbt_state_t st;
    logic [CBT_IR_W-1:0] ir;
    logic [CBT_IR_W-1:0] ir_sr;
    logic [CBT_BSR_LEN-1:0] bsr_sr;
    logic [CBT_BSR_LEN-1:0] bsr_upd;
    logic byp;
    logic drive_mode;
    logic hiz_mode;
    logic upd_tgl;
    cbt_pins_t pin_s1;
    cbt_pins_t pin_s2;
  } cbt_tck_t;

  // falling-edge output stage
  typedef struct packed {
    logic tdo;
    logic oe;
  } cbt_out_t;

  // system clock domain state
  typedef struct packed {
    logic drv_s1;
    logic drv_s2;
    logic hiz_s1;
    logic hiz_s2;
    logic tgl_s1;
    logic tgl_s2;
    logic tgl_s3;
    logic [CBT_BSR_LEN-1:0] upd;
    cbt_pins_t pad;
    logic hiz;
    logic test_mode;
  } cbt_ref_t;

  localparam cbt_tck_t TCK_RST = '{
    st: CBT_TLR,
    ir: CBT_IR_BYPASS,
    ir_sr: CBT_IR_BYPASS,
    bsr_sr: '0,
    bsr_upd: '0,
    byp: 1'b0,
    drive_mode: 1'b0,
    hiz_mode: 1'b0,
    upd_tgl: 1'b0,
    pin_s1: CBT_PINS_RST,
    pin_s2: CBT_PINS_RST
  };

  cbt_tck_t t_ff, nxt_t;
  cbt_out_t o_ff, nxt_o;
  cbt_ref_t r_ff, nxt_r;
  logic tms;
  logic tdi;
  logic bsr_sel;

  // a floating test input behaves as a driven one
  assign tms = tms_driven ? tms_pin : 1'b1;
  assign tdi = tdi_driven ? tdi_pin : 1'b1;

  // boundary chain is the data path only for extest and sample
  assign bsr_sel = (t_ff.ir == CBT_IR_EXTEST) ||
                   (t_ff.ir == CBT_IR_SAMPLE);

  // controller, shifters and pad synchronisers, all on rising tck
  always_comb begin
    nxt_t = t_ff;
    // pad values come from the system side, so two stages first
    nxt_t.pin_s1 = pad_in;
    nxt_t.pin_s2 = t_ff.pin_s1;
    // next state decided only by the sampled mode select
    case (t_ff.st)
      CBT_TLR: nxt_t.st = tms ? CBT_TLR : CBT_RTI;
      CBT_RTI: nxt_t.st = tms ? CBT_SEL_DR : CBT_RTI;
      CBT_SEL_DR: nxt_t.st = tms ? CBT_SEL_IR : CBT_CAP_DR;
      CBT_CAP_DR: nxt_t.st = tms ? CBT_EX1_DR : CBT_SH_DR;
      CBT_SH_DR: nxt_t.st = tms ? CBT_EX1_DR : CBT_SH_DR;
      CBT_EX1_DR: nxt_t.st = tms ? CBT_UPD_DR : CBT_PAU_DR;
      CBT_PAU_DR: nxt_t.st = tms ? CBT_EX2_DR : CBT_PAU_DR;
      CBT_EX2_DR: nxt_t.st = tms ? CBT_UPD_DR : CBT_SH_DR;
      CBT_UPD_DR: nxt_t.st = tms ? CBT_SEL_DR : CBT_RTI;
      CBT_SEL_IR: nxt_t.st = tms ? CBT_TLR : CBT_CAP_IR;
      CBT_CAP_IR: nxt_t.st = tms ? CBT_EX1_IR : CBT_SH_IR;
      CBT_SH_IR: nxt_t.st = tms ? CBT_EX1_IR : CBT_SH_IR;
      CBT_EX1_IR: nxt_t.st = tms ? CBT_UPD_IR : CBT_PAU_IR;
      CBT_PAU_IR: nxt_t.st = tms ? CBT_EX2_IR : CBT_PAU_IR;
      CBT_EX2_IR: nxt_t.st = tms ? CBT_UPD_IR : CBT_SH_IR;
      CBT_UPD_IR: nxt_t.st = tms ? CBT_SEL_DR : CBT_RTI;
      default: nxt_t.st = CBT_TLR;
    endcase
    // per-state actions of the current state
    case (t_ff.st)
      CBT_TLR: begin
        // only test-side state is cleared, system pins keep core values
        nxt_t.ir = CBT_IR_BYPASS;
        nxt_t.drive_mode = 1'b0;
        nxt_t.hiz_mode = 1'b0;
      end
      CBT_CAP_IR: begin
        nxt_t.ir_sr = CBT_IR_CAPTURE;
      end
      CBT_SH_IR: begin
        nxt_t.ir_sr = {tdi, t_ff.ir_sr[CBT_IR_W-1:1]};
      end
      CBT_UPD_IR: begin
        // new instruction takes effect on the edge leaving update
        nxt_t.ir = t_ff.ir_sr;
        nxt_t.drive_mode = (t_ff.ir_sr == CBT_IR_EXTEST) ||
                           (t_ff.ir_sr == CBT_IR_CLAMP);
        nxt_t.hiz_mode = (t_ff.ir_sr == CBT_IR_HIGHZ);
        nxt_t.upd_tgl = ~t_ff.upd_tgl;
      end
      CBT_CAP_DR: begin
        // under extest or sample load every pin into the chain, bypass captures zero
        if (bsr_sel) begin
          nxt_t.bsr_sr = t_ff.pin_s2;
        end
        nxt_t.byp = 1'b0;
      end
      CBT_SH_DR: begin
        if (bsr_sel) begin
          nxt_t.bsr_sr = {tdi, t_ff.bsr_sr[CBT_BSR_LEN-1:1]};
        end else begin
          nxt_t.byp = tdi;
        end
      end
      CBT_UPD_DR: begin
        // under clamp the chain is out of the path: preload is kept
        if (bsr_sel) begin
          nxt_t.bsr_upd = t_ff.bsr_sr;
          nxt_t.upd_tgl = ~t_ff.upd_tgl;
        end
      end
      default: begin
        nxt_t.byp = t_ff.byp;
      end
    endcase
  end

  // asynchronous test reset needs no tck edge
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      t_ff <= TCK_RST;
    end else begin
      t_ff <= nxt_t;
    end
  end

  // serial output mux, driven only in the two shift states
  always_comb begin
    nxt_o.oe = (t_ff.st == CBT_SH_IR) || (t_ff.st == CBT_SH_DR);
    if (t_ff.st == CBT_SH_IR) begin
      nxt_o.tdo = t_ff.ir_sr[0];
    end else if (t_ff.st == CBT_SH_DR) begin
      nxt_o.tdo = bsr_sel ? t_ff.bsr_sr[0] : t_ff.byp;
    end else begin
      nxt_o.tdo = 1'b0;
    end
  end

  // output stage changes only on falling tck
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      o_ff <= '0;
    end else begin
      o_ff <= nxt_o;
    end
  end

  assign tdo = o_ff.tdo;
  assign tdo_oe = o_ff.oe;

  // system side: mode levels by two stages, the preload word by toggle
  always_comb begin
    nxt_r = r_ff;
    nxt_r.drv_s1 = t_ff.drive_mode;
    nxt_r.drv_s2 = r_ff.drv_s1;
    nxt_r.hiz_s1 = t_ff.hiz_mode;
    nxt_r.hiz_s2 = r_ff.hiz_s1;
    nxt_r.tgl_s1 = t_ff.upd_tgl;
    nxt_r.tgl_s2 = r_ff.tgl_s1;
    nxt_r.tgl_s3 = r_ff.tgl_s2;
    // word is stable: the next update needs several tck cycles
    if (r_ff.tgl_s2 != r_ff.tgl_s3) begin
      nxt_r.upd = t_ff.bsr_upd;
    end
    // core keeps the pads unless extest or clamp is in force
    nxt_r.pad = r_ff.drv_s2 ? cbt_pins_t'(r_ff.upd) : core_out;
    nxt_r.hiz = r_ff.hiz_s2;
    nxt_r.test_mode = r_ff.drv_s2;
  end

  // system reset is synchronous
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign pad_out = r_ff.pad;
  assign pad_hiz = r_ff.hiz;
  assign pad_test_mode = r_ff.test_mode;

endmodule : cbt_tap

`default_nettype wire

// [hw/cbt_pkg.sv]
// package: constants, states and pin carrier of the cam boundary-scan tap
package cbt_pkg;

  // instruction register
  localparam int CBT_IR_W = 4;
  localparam logic [3:0] CBT_IR_BYPASS = 4'hf;
  localparam logic [3:0] CBT_IR_SAMPLE = 4'h2;
  localparam logic [3:0] CBT_IR_EXTEST = 4'h0;
  localparam logic [3:0] CBT_IR_HIGHZ = 4'h9;
  localparam logic [3:0] CBT_IR_CLAMP = 4'hc;
  // fixed pattern loaded into the instruction shifter on capture
  localparam logic [3:0] CBT_IR_CAPTURE = 4'h1;

  // boundary chain, cell 1 sits at bit 0 and leaves first
  localparam int CBT_BSR_LEN = 63;

  // tap controller states
  typedef enum logic [3:0] {
    CBT_TLR, CBT_RTI,
    CBT_SEL_DR, CBT_CAP_DR, CBT_SH_DR, CBT_EX1_DR,
    CBT_PAU_DR, CBT_EX2_DR, CBT_UPD_DR,
    CBT_SEL_IR, CBT_CAP_IR, CBT_SH_IR, CBT_EX1_IR,
    CBT_PAU_IR, CBT_EX2_IR, CBT_UPD_IR
  } cbt_state_t;

  // device pins in chain order; the last field is cell 1
  typedef struct packed {
    logic transfer_acknowledge_out;     // cell 63
    logic control_interrupt_out;        // cell 62
    logic dev_reset;                    // cell 61
    logic chip_sel;                     // cell 60
    logic wr_en;                        // cell 59
    logic [0:2] control_port_address;   // cells 56..58, bit 2 first
    logic if_clk;                       // cell 55
    logic [0:15] control_port_data_bus; // cells 39..54, bit 15 first
    logic [0:15] match_result_bus_lo;   // cells 23..38, bit 15 first
    logic long_low_in;                  // cell 22
    logic long_high_strobe;             // cell 21
    logic [16:31] match_result_bus_hi;  // cells 5..20, bit 31 first
    logic match_control_in;             // cell 4
    logic path_circuit_select;          // cell 3
    logic match_strobe_in;              // cell 2
    logic out_en_n;                     // cell 1
  } cbt_pins_t;

  localparam cbt_pins_t CBT_PINS_RST = '0;

endpackage : cbt_pkg

// [test/cbt_tap_asserts.sv]
// checker: port relations of the cam boundary-scan tap
`timescale 1ns/1ps
`default_nettype none
module cbt_tap_asserts (
  // clocks and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tck,
  input wire logic trst_n,
  // test port
  input wire logic tms_pin,
  input wire logic tms_driven,
  input wire logic tdo,
  input wire logic tdo_oe,
  // pads
  input wire cbt_pkg::cbt_pins_t core_out,
  input wire cbt_pkg::cbt_pins_t pad_out,
  input wire logic pad_hiz,
  input wire logic pad_test_mode
);
  import cbt_pkg::*;
  logic tms_eff;
  // a floating select steers the controller like a one
  assign tms_eff = tms_pin | ~tms_driven;
  chk_tdo_quiet: assert property (@(posedge tck) disable iff (!trst_n)
    !tdo_oe |-> !tdo) else $error("tdo active while idle");
  chk_shift_entry: assert property (@(posedge tck) disable iff (!trst_n)
    $rose(tdo_oe) |-> !$past(tms_eff)) else $error("shift entered on high");
  chk_shift_exit: assert property (@(posedge tck) disable iff (!trst_n)
    $past(trst_n) && $fell(tdo_oe) |-> $past(tms_eff))
    else $error("shift left on low");
  chk_shift_hold: assert property (@(posedge tck) disable iff (!trst_n)
    tdo_oe && !tms_eff |=> tdo_oe) else $error("shift dropped early");
  chk_shift_leave: assert property (@(posedge tck) disable iff (!trst_n)
    tdo_oe && tms_eff |=> !tdo_oe) else $error("shift kept on high");
  chk_trst_now: assert property (@(posedge ref_clk) disable iff (rst)
    !trst_n |-> !tdo_oe && !tdo) else $error("port active in reset");
  chk_mode_excl: assert property (@(posedge ref_clk) disable iff (rst)
    !(pad_hiz && pad_test_mode)) else $error("two modes at once");
  chk_pad_follow: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) && !$past(rst, 2) && !pad_test_mode && !$past(pad_test_mode)
    |-> pad_out == $past(core_out)) else $error("pads not following core");
endmodule : cbt_tap_asserts
bind cbt_tap cbt_tap_asserts cbt_tap_asserts_inst (.*);
`default_nettype wire

// [test/cbt_tester.sv]
// tester model: drives the test port from the board side
`timescale 1ns/1ps
`default_nettype none
module cbt_tester (
  // test port toward the device
  output logic tck,
  output logic trst_n,
  output logic tms_pin,
  output logic tms_driven,
  output logic tdi_pin,
  output logic tdi_driven
);
  // idle port: clock parked low between frames
  initial begin
    tck = 1'b0;
    trst_n = 1'b0;
    {tms_pin, tms_driven, tdi_pin, tdi_driven} = 4'hf;
  end
  // one clock; a released line toggles so no stale level survives
  task step(input logic [1:0] drv, input logic m, input logic d);
    {tms_driven, tdi_driven} = drv;
    tms_pin = drv[1] ? m : ~tms_pin;
    tdi_pin = drv[0] ? d : ~tdi_pin;
    #7.5 tck = 1'b1;
    #7.5 tck = 1'b0;
  endtask : step
  // test reset while the clock stands still
  task pulse_trst();
    trst_n = 1'b0;
    #20 trst_n = 1'b1;
  endtask : pulse_trst
endmodule : cbt_tester
`default_nettype wire

// [test/testbench.sv]
// testbench: tap walk, scan patterns, modes and resets
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cbt_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic tck, trst_n, tms_pin, tms_driven, tdi_pin, tdi_driven, tdo, tdo_oe;
  logic pad_hiz, pad_test_mode;
  cbt_pins_t pad_in, core_q, pad_out, pat;
  cbt_pins_t core_out = '0;
  logic exp_q[$];
  int fail_count = 0;
  int compares = 0;
  logic [31:0] seed = 32'h452d;
  always #12.5 ref_clk = ~ref_clk;
  cbt_tester cbt_tester_inst (.*);
  cbt_tap cbt_tap_inst (.*);
  function automatic logic [62:0] rnd();
    repeat (2) begin
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
    end
    return {seed[30:0], seed};
  endfunction : rnd
  task check(input string what, input logic [62:0] seen, input logic [62:0] ex);
    compares++;
    if (seen !== ex) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, ex, seen);
    end
  endtask : check
  task give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // core keeps moving so a disturbed pad path shows up
  always @(posedge ref_clk) begin
    core_q <= core_out;
    core_out <= rnd();
  end
  // each serial bit is matched to the oldest note as it leaves
  always @(posedge tck) begin
    if (tdo_oe === 1'b1 && exp_q.size() > 0)
      check("tdo", 63'(tdo), 63'(exp_q.pop_front()));
  end
  // n bits lsb first, then exit, update and back to idle
  task shift(input int n, input logic [62:0] din, ex, input logic [1:0] drv);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(ex[i]);
      cbt_tester_inst.step(drv, i == n - 1, din[i]);
    end
    cbt_tester_inst.step(2'b11, 1'b1, 1'b0);
    cbt_tester_inst.step(2'b11, 1'b0, 1'b0);
  endtask : shift
  task ir(input logic [3:0] code);
    for (int i = 0; i < 4; i++) cbt_tester_inst.step(2'b11, i < 2, 1'b0);
    shift(4, 63'(code), 63'(CBT_IR_CAPTURE), 2'b11);
  endtask : ir
  task dr(input int n, input logic [62:0] din, ex, input logic [1:0] drv);
    for (int i = 0; i < 3; i++) cbt_tester_inst.step(2'b11, i == 0, 1'b0);
    shift(n, din, ex, drv);
  endtask : dr
  // modes cross two stages; pads need a little longer
  task wait_mode(input logic t, input logic h);
    int n;
    n = 0;
    while ((pad_test_mode !== t || pad_hiz !== h) && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    check("mode", 63'({pad_test_mode, pad_hiz}), 63'({t, h}));
    if (n == 20) give_verdict();
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : wait_mode
  initial begin
    pad_in = '0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    pad_in <= rnd();
    pat = rnd();
    cbt_tester_inst.pulse_trst();
    cbt_tester_inst.step(2'b11, 1'b0, 1'b0);
    ir(CBT_IR_SAMPLE);
    dr(63, pat, pad_in, 2'b11);
    ir(CBT_IR_EXTEST);
    wait_mode(1'b1, 1'b0);
    check("preload", pad_out, pat);
    ir(CBT_IR_CLAMP);
    dr(2, 63'h0, 63'h2, 2'b10);
    check("clamp", pad_out, pat);
    cbt_tester_inst.pulse_trst();
    wait_mode(1'b0, 1'b0);
    check("core", pad_out, core_q);
    cbt_tester_inst.step(2'b11, 1'b0, 1'b0);
    ir(CBT_IR_HIGHZ);
    wait_mode(1'b0, 1'b1);
    repeat (5) cbt_tester_inst.step(2'b01, 1'b0, 1'b0);
    wait_mode(1'b0, 1'b0);
    // every noted serial bit must have left the port
    check("queue", 63'(exp_q.size()), 63'h0);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
